// ---- tb_top.sv ----
// testbench for the failover controller
`timescale 1ns/1ps
module tb_top;
  import upfc_pkg::*;
  logic        clk, rstn, hrst, wr, rd, pa_dd, pc_dd, pa_ts, pc_ts, pbr, pcr, trn;
  logic        ack, fdet, swap, rtr, irst, erst, mask;
  logic [7:0]  idx, gin, gout, goe, dly;
  logic [3:0]  be;
  logic [2:0]  lup;
  logic [31:0] wd, rdat, v;
  int          errors, compares, nfo, n0;
  logic [7:0]  tc [8] = '{8'h00, 8'h08, 8'h00, 8'h10, 8'h00, 8'h40, 8'h00, 8'h80};
  logic [1:0]  tx [8] = '{2'b11, 2'b00, 2'bx1, 2'bx0, 2'b1x, 2'b0x, 2'bx1, 2'bx0};

  upfc_top DUT (
    .core_clk_i(clk), .rstn_i(rstn), .hot_rst_i(hrst), .cfg_wr_i(wr), .cfg_rd_i(rd),
    .cfg_idx_i(idx), .cfg_be_i(be), .cfg_wdata_i(wd), .cfg_rdata_o(rdat),
    .cfg_ack_o(ack), .gpio_in_i(gin), .gpio_out_o(gout), .gpio_oe_o(goe),
    .port_b_rst_i(pbr), .port_c_rst_i(pcr), .linkup_i(lup), .pa_dl_down_i(pa_dd),
    .pc_dl_down_i(pc_dd), .pa_ts1_hrst_i(pa_ts), .pc_ts1_hrst_i(pc_ts),
    .pa_trained_i(trn), .pc_trained_i(trn), .force_detect_o(fdet),
    .lane_swap_o(swap), .retrain_o(rtr), .int_dom_rst_o(irst),
    .ext_dom_rst_o(erst), .link_evt_mask_o(mask));
  upfc_link_model u_link (.core_clk_i(clk), .rstn_i(rstn), .retrain_i(rtr),
    .delay_i(dly), .trained_o(trn));

  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  always @(posedge fdet) nfo++;

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic cfg(input logic w, input logic [7:0] i, input logic [31:0] d);
    @(posedge clk); #1;
    wr = w;
    rd = !w;
    idx = i;
    wd = d;
    @(posedge clk); #1;
    wr = 0;
    rd = 0;
    chk("ack", 1, ack);
    v = rdat;
  endtask : cfg
  task automatic wait_fo(input int lo, input int hi);
    int k;
    k = 0;
    while (fdet !== 1'b1 && k < hi) begin
      @(posedge clk); #1;
      k++;
    end
    chk("start", 1, fdet === 1'b1 && k >= lo);
  endtask : wait_fo
  task automatic wait_idle;
    int k;
    k = 0;
    while (mask !== 1'b0 && k < 3000) begin
      @(posedge clk); #1;
      k++;
    end
    chk("idle", 0, mask);
  endtask : wait_idle
  task automatic pulse(input int s, input logic [1:0] e);
    @(posedge clk); #1;
    case (s)
      0: pa_dd = 1;
      1: pc_dd = 1;
      2: pa_ts = 1;
      default: pc_ts = 1;
    endcase
    @(posedge clk); #1;
    {pa_dd, pc_dd, pa_ts, pc_ts} = 4'h0;
    if (e[1] !== 1'bx) chk("int_rst", e[1], irst);
    if (e[0] !== 1'bx) chk("ext_rst", e[0], erst);
  endtask : pulse

  task automatic t_regs;
    cfg(0, UPFC_IDX_CTL, 0);
    chk("ctl", 0, v);
    cfg(0, UPFC_IDX_GPIO, 0);
    chk("gpio", 0, v);
    cfg(1, 8'h40, 32'hFFFFFFFF);
    cfg(0, 8'h40, 0);
    chk("unmapped", 0, v);
    cfg(0, UPFC_IDX_CTL, 0);
    chk("ctl_kept", 0, v);
  endtask : t_regs
  task automatic t_rstmask;
    for (int i = 0; i < 8; i++) begin
      cfg(1, UPFC_IDX_CTL, {24'h0, tc[i]});
      pulse(i / 2, tx[i]);
    end
  endtask : t_rstmask
  task automatic t_gpio;
    gin = 8'h5A;
    cfg(1, UPFC_IDX_GPIO, 32'h00A50F00);
    repeat (4) @(posedge clk);
    chk("oe", 8'h0F, goe);
    chk("out", 8'h05, gout & 8'h0F);
    cfg(0, UPFC_IDX_GPIO, 0);
    chk("gpio_rd", 32'h005A0F00, v);
    pbr = 1;
    lup = 3'b101;
    cfg(1, UPFC_IDX_GPIO, 32'h0000001F);
    repeat (4) @(posedge clk);
    chk("alt_oe", 8'h1F, goe & 8'h3F);
    chk("alt_out", 8'h16, gout & 8'h1F);
  endtask : t_gpio
  task automatic t_sw;
    n0 = nfo;
    dly = 200;
    cfg(1, UPFC_IDX_CTL, 1);
    wait_fo(0, 3);
    hrst = 1;
    @(posedge clk); #1;
    hrst = 0;
    wait_idle;
    chk("swap", 1, swap);
    cfg(0, UPFC_IDX_STS, 0);
    chk("sts", 7, v);
    cfg(1, UPFC_IDX_STS, 6);
    cfg(0, UPFC_IDX_STS, 0);
    chk("sts_clr", 1, v);
    chk("count", 1, nfo - n0);
  endtask : t_sw
  task automatic t_queue;
    n0 = nfo;
    cfg(1, UPFC_IDX_CTL, 4);
    wait_fo(0, 3);
    cfg(1, UPFC_IDX_TIMER, 2);
    wait_idle;
    wait_fo(0, 100);
    wait_idle;
    chk("q_count", 2, nfo - n0);
    chk("q_swap", 1, swap);
  endtask : t_queue
  task automatic t_wdt;
    n0 = nfo;
    cfg(1, UPFC_IDX_TIMER, 2);
    hrst = 1;
    @(posedge clk); #1;
    hrst = 0;
    wait_fo(45, 110);
    cfg(1, UPFC_IDX_TIMER, 1);
    wait_idle;
    repeat (200) @(posedge clk);
    chk("w_count", 1, nfo - n0);
    chk("w_swap", 0, swap);
    cfg(0, UPFC_IDX_TIMER, 0);
    chk("timer", 0, v);
  endtask : t_wdt
  task automatic t_pin;
    gin = 8'h00;
    dly = 2;
    cfg(1, UPFC_IDX_CTL, 32'h22);
    repeat (4) @(posedge clk); #1;
    gin[5] = 1;
    wait_fo(2, 8);
    pulse(0, 2'b00);
    wait_idle;
    chk("p_swap", 1, swap);
    cfg(1, UPFC_IDX_GPIO, 32'h20);
    gin[5] = 0;
    wait_fo(2, 8);
    wait_idle;
    chk("p_swap0", 0, swap);
  endtask : t_pin

  task automatic print_verdict;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : print_verdict

  initial begin
    {rstn, hrst, wr, rd, pa_dd, pc_dd, pa_ts, pc_ts, pbr, pcr} = 10'h0;
    {idx, gin, dly, wd, lup} = 0;
    be = 4'hF;
    repeat (10) @(posedge clk); #1;
    rstn = 1;
    t_regs;
    t_rstmask;
    t_gpio;
    t_sw;
    t_queue;
    t_wdt;
    t_pin;
    print_verdict;
  end
  initial begin
    #400000;
    errors++;
    print_verdict;
  end
endmodule : tb_top

// ---- upfc_link_model.sv ----
// link partner: reports both links trained some cycles after retrain starts
`timescale 1ns/1ps
module upfc_link_model (
  input  wire logic       core_clk_i, // core clock
  input  wire logic       rstn_i,     // reset, active low
  input  wire logic       retrain_i,  // retrain request
  input  wire logic [7:0] delay_i,    // cycles to train
  output logic            trained_o   // both links trained
);
  logic [7:0] cnt;
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i)
      cnt <= 8'h00;
    else if (!retrain_i)
      cnt <= 8'h00;
    else if (cnt != 8'hFF)
      cnt <= cnt + 8'h01;
  end
  // drops with the request, so a stale trained level never ends a later retrain
  assign trained_o = retrain_i && (cnt >= delay_i);
endmodule : upfc_link_model

// ---- upfc_pkg.sv ----
// shared constants and types for the upstream port failover controller
package upfc_pkg;
  // config-space word indices (byte address = index * 4); values arbitrary
  localparam logic [7:0]  UPFC_IDX_CTL     = 8'h00;
  localparam logic [7:0]  UPFC_IDX_STS     = 8'h01;
  localparam logic [7:0]  UPFC_IDX_TIMER   = 8'h02;
  localparam logic [7:0]  UPFC_IDX_GPIO    = 8'h03;
  // control register field positions
  localparam int          UPFC_CTL_MSEL    = 0;
  localparam int          UPFC_CTL_PIN_TRIGGER_ENABLE  = 1;
  localparam int          UPFC_CTL_TIMER_TRIGGER_ENABLE  = 2;
  localparam int          UPFC_CTL_IDLD    = 3;
  localparam int          UPFC_CTL_EDLD    = 4;
  localparam int          UPFC_CTL_DFH     = 5;
  localparam int          UPFC_CTL_IDPROP  = 6;
  localparam int          UPFC_CTL_EDPROP  = 7;
  // status register field positions
  localparam int          UPFC_STS_CMODE   = 0;
  localparam int          UPFC_STS_INIT    = 1;
  localparam int          UPFC_STS_DONE    = 2;
  // gpio register field positions
  localparam int          UPFC_GPIO_FUNC   = 0;
  localparam int          UPFC_GPIO_DIR    = 8;
  localparam int          UPFC_GPIO_DATA   = 16;
  localparam int          UPFC_FOVR_PIN    = 5;
  // reset values
  localparam logic [7:0]  UPFC_CTL_RST     = 8'h00;
  localparam logic [7:0]  UPFC_GPIO_RST    = 8'h00;
  localparam logic [31:0] UPFC_TIMER_RST   = 32'h00000000;
  // timing
  localparam int          UPFC_CLK_MHZ     = 50;
  localparam int          UPFC_TICK_US     = 1;
  localparam int          UPFC_TICK_CYC    = UPFC_CLK_MHZ * UPFC_TICK_US;
  localparam int          UPFC_DETECT_CYC  = 16;
  // trigger sources, also queue bit order
  localparam int          UPFC_SRC_SW      = 0;
  localparam int          UPFC_SRC_PIN     = 1;
  localparam int          UPFC_SRC_WDT     = 2;
  typedef enum logic [1:0] {UPFC_IDLE, UPFC_DETECT, UPFC_RETRAIN} upfc_state_e;
endpackage : upfc_pkg

// ---- upfc_properties.sv ----
// port-level checks of the failover controller
`timescale 1ns/1ps
module upfc_properties (
  input wire logic        core_clk_i,     // core clock
  input wire logic        rstn_i,         // reset, active low
  input wire logic        hot_rst_i,      // hot reset
  input wire logic        cfg_wr_i,       // write strobe
  input wire logic        cfg_rd_i,       // read strobe
  input wire logic [31:0] cfg_rdata_o,    // read data
  input wire logic        cfg_ack_o,      // access done
  input wire logic        pa_dl_down_i,   // port A down
  input wire logic        pc_dl_down_i,   // port C down
  input wire logic        pa_ts1_hrst_i,  // upstream TS1 reset
  input wire logic        pc_ts1_hrst_i,  // port C TS1 reset
  input wire logic        pa_trained_i,   // A trained
  input wire logic        pc_trained_i,   // C trained
  input wire logic        force_detect_o, // detect phase
  input wire logic        lane_swap_o,    // mode
  input wire logic        retrain_o,      // retrain phase
  input wire logic        int_dom_rst_o,  // internal reset
  input wire logic        ext_dom_rst_o,  // external reset
  input wire logic        link_evt_mask_o // event mask
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  sequence s_enter;
    $rose(force_detect_o);
  endsequence
  sequence s_relink;
    !force_detect_o && retrain_o;
  endsequence
  a_detect_then_retrain: assert property (s_enter |-> ##16 s_relink)
    else $error("detect phase length wrong");
  a_lane_hold_detect: assert property (force_detect_o |-> $stable(lane_swap_o))
    else $error("lanes moved during detect");
  a_retrain_end: assert property (retrain_o && pa_trained_i && pc_trained_i |=> !retrain_o)
    else $error("retrain did not end");
  a_mask_running: assert property ((force_detect_o || retrain_o) |-> link_evt_mask_o)
    else $error("link events unmasked in failover");
  a_ack_resp: assert property ((cfg_wr_i || cfg_rd_i) |=> cfg_ack_o)
    else $error("access not acknowledged");
  a_ack_cause: assert property (cfg_ack_o |-> $past(cfg_wr_i || cfg_rd_i))
    else $error("ack without access");
  a_rdata_idle: assert property (!cfg_ack_o |-> cfg_rdata_o == 32'h0)
    else $error("read data outside ack");
  a_int_rst_cause: assert property (int_dom_rst_o |->
    $past(pa_dl_down_i || pa_ts1_hrst_i || hot_rst_i))
    else $error("internal reset without cause");
  a_ext_rst_cause: assert property (ext_dom_rst_o |->
    $past(pa_dl_down_i || pc_dl_down_i || pc_ts1_hrst_i))
    else $error("external reset without cause");
endmodule : upfc_properties

bind upfc_top upfc_properties u_props (
  .core_clk_i(core_clk_i), .rstn_i(rstn_i), .hot_rst_i(hot_rst_i),
  .cfg_wr_i(cfg_wr_i), .cfg_rd_i(cfg_rd_i), .cfg_rdata_o(cfg_rdata_o),
  .cfg_ack_o(cfg_ack_o), .pa_dl_down_i(pa_dl_down_i), .pc_dl_down_i(pc_dl_down_i),
  .pa_ts1_hrst_i(pa_ts1_hrst_i), .pc_ts1_hrst_i(pc_ts1_hrst_i),
  .pa_trained_i(pa_trained_i), .pc_trained_i(pc_trained_i),
  .force_detect_o(force_detect_o), .lane_swap_o(lane_swap_o), .retrain_o(retrain_o),
  .int_dom_rst_o(int_dom_rst_o), .ext_dom_rst_o(ext_dom_rst_o),
  .link_evt_mask_o(link_evt_mask_o));

// ---- upfc_sync.sv ----
// two-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module upfc_sync #(
  parameter int W = 8
) (
  input  wire logic         core_clk_i, // core clock
  input  wire logic         rstn_i,     // async reset, active low
  input  wire logic [W-1:0] async_i,    // raw pin levels
  output logic      [W-1:0] sync_o      // synchronised levels
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } upfc_sync_s;
  upfc_sync_s st;
  upfc_sync_s next_st;

  always_comb begin
    next_st.meta   = async_i;
    next_st.stable = st.meta;
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sync_o = st.stable;
endmodule : upfc_sync

// ---- upfc_top.sv ----
// failover trigger arbitration, reset masking and eight-pin gpio port
// Summary of operation
// - same-type trigger during failover is dropped
// - other-type trigger queued until current completes
// - mode select change starts failover
// - pin enabled and differing from mode triggers
// - request signal always follows gpio pin five
// - pin low normal, high swapped
// - timer enabled and count one-to-zero triggers
// - count decrements each microsecond until zero
// - software write reloads watchdog count
// - watchdog survives hot reset
// - watchdog failover picks opposite mode
// - internal link-down disable masks port A reset
// - external link-down disable masks port C reset
// - failover disable masks failover-caused link-down resets
// - internal propagation disable ignores upstream TS1 reset
// - external propagation disable ignores port C TS1 reset
// - function bits select alternate or gpio
// - direction bits select output or input
// - data reads pins, writes drive outputs
// - pins 0-4 alternate functions, top byte zero
// - sticky initiated and completed flags
// - force detect, swap lanes, then retrain
// - sequence runs to end, hot reset ignored
// - failover link events masked from interrupt status
`timescale 1ns/1ps
module upfc_top
  import upfc_pkg::*;
#(
  parameter int NPIN = 8,
  parameter int CW   = 32
) (
  input  wire logic            core_clk_i,     // core clock, 50 MHz
  input  wire logic            rstn_i,         // fundamental reset, active low
  input  wire logic            hot_rst_i,      // hot reset pulse
  input  wire logic            cfg_wr_i,       // config write strobe
  input  wire logic            cfg_rd_i,       // config read strobe
  input  wire logic [7:0]      cfg_idx_i,      // register word index
  input  wire logic [3:0]      cfg_be_i,       // byte enables
  input  wire logic [31:0]     cfg_wdata_i,    // write data
  output logic      [31:0]     cfg_rdata_o,    // read data
  output logic                 cfg_ack_o,      // access done
  input  wire logic [NPIN-1:0] gpio_in_i,      // pin levels
  output logic      [NPIN-1:0] gpio_out_o,     // pin drive values
  output logic      [NPIN-1:0] gpio_oe_o,      // pin drive enables
  input  wire logic            port_b_rst_i,   // port B reset, active high
  input  wire logic            port_c_rst_i,   // port C reset, active high
  input  wire logic [2:0]      linkup_i,       // link up of ports A,B,C
  input  wire logic            pa_dl_down_i,   // port A entered DL_Down
  input  wire logic            pc_dl_down_i,   // port C link down
  input  wire logic            pa_ts1_hrst_i,  // upstream TS1 hot reset
  input  wire logic            pc_ts1_hrst_i,  // port C TS1 hot reset
  input  wire logic            pa_trained_i,   // port A retrained
  input  wire logic            pc_trained_i,   // port C retrained
  output logic                 force_detect_o, // hold ports A,C in Detect
  output logic                 lane_swap_o,    // serdes swapped when high
  output logic                 retrain_o,      // start retraining A,C
  output logic                 int_dom_rst_o,  // reset internal domain
  output logic                 ext_dom_rst_o,  // reset external domain
  output logic                 link_evt_mask_o // mask link interrupt bits
);
  typedef struct packed {
    logic [7:0]      ctl;
    logic            cmode;
    logic            init_f;
    logic            done_f;
    logic            target;
    logic            busy_src_v;
    logic [1:0]      busy_src;
    logic [2:0]      pend;
    logic [2:0]      pend_mode;
    upfc_state_e     state;
    logic [4:0]      dcnt;
    logic [NPIN-1:0] func;
    logic [NPIN-1:0] dir;
    logic [NPIN-1:0] dout;
    logic [31:0]     rdata;
    logic            ack;
    logic [NPIN-1:0] gout;
    logic [NPIN-1:0] goe;
    logic            force_det;
    logic            retrain;
    logic            int_rst;
    logic            ext_rst;
    logic            mask;
  } upfc_top_s;
  upfc_top_s st;
  upfc_top_s next_st;

  logic [NPIN-1:0] pins_sync;
  logic [CW-1:0]   wdt_count;
  logic            wdt_expire;
  logic            wdt_load;

  function automatic logic [31:0] upfc_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : upfc_merge

  upfc_sync #(.W(NPIN)) u_sync (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .async_i    (gpio_in_i),
    .sync_o     (pins_sync)
  );

  assign wdt_load = cfg_wr_i && (cfg_idx_i == UPFC_IDX_TIMER);

  upfc_wdt #(.CW(CW)) u_wdt (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .load_i     (wdt_load),
    .load_val_i (CW'(upfc_merge(32'(wdt_count), cfg_wdata_i, cfg_be_i))),
    .count_o    (wdt_count),
    .expire_o   (wdt_expire)
  );

  logic       fovr_req;
  logic [2:0] trig;
  logic [2:0] trig_mode;
  logic [7:0] ctl_wr;
  logic [NPIN-1:0] alt_out;
  logic       busy;
  logic       in_fovr;
  logic [31:0] ctl_m;
  logic       fo_start;
  logic       fo_done;
  logic       pick_v;
  logic [1:0] pick;

  always_comb begin
    next_st     = st;
    next_st.ack = cfg_wr_i | cfg_rd_i;
    fovr_req    = pins_sync[UPFC_FOVR_PIN];
    busy        = (st.state != UPFC_IDLE);
    in_fovr     = busy;
    ctl_m       = upfc_merge({24'h0, st.ctl}, cfg_wdata_i, cfg_be_i);
    ctl_wr      = ctl_m[7:0];
    fo_done     = (st.state == UPFC_RETRAIN) && pa_trained_i && pc_trained_i;
    trig        = '0;
    trig_mode   = '0;

    // software trigger: any change of select field
    if (cfg_wr_i && cfg_idx_i == UPFC_IDX_CTL) begin
      next_st.ctl = ctl_wr;
      if (ctl_wr[UPFC_CTL_MSEL] != st.ctl[UPFC_CTL_MSEL]) begin
        trig[UPFC_SRC_SW]      = 1'b1;
        trig_mode[UPFC_SRC_SW] = ctl_wr[UPFC_CTL_MSEL];
      end
    end
    // pin trigger is a level compare; it holds off while a failover already targets the pin level
    if (st.ctl[UPFC_CTL_PIN_TRIGGER_ENABLE] && fovr_req != st.cmode &&
        !(busy && st.target == fovr_req)) begin
      trig[UPFC_SRC_PIN]      = 1'b1;
      trig_mode[UPFC_SRC_PIN] = fovr_req;
    end
    if (st.ctl[UPFC_CTL_TIMER_TRIGGER_ENABLE] && wdt_expire) begin
      trig[UPFC_SRC_WDT]      = 1'b1;
      trig_mode[UPFC_SRC_WDT] = ~st.cmode;
    end

    // queue triggers of a type other than the running one
    for (int s = 0; s < 3; s++) begin
      if (trig[s]) begin
        if (busy && st.busy_src_v && st.busy_src == 2'(s)) begin
        end else begin
          // idle triggers queue too, so simultaneous ones are not lost
          next_st.pend[s]      = 1'b1;
          next_st.pend_mode[s] = trig_mode[s];
        end
      end
    end
    // highest pending source starts first: watchdog, pin, software
    pick_v = 1'b0;
    pick   = '0;
    for (int s = 0; s < 3; s++) begin
      if (next_st.pend[s]) begin
        pick_v = 1'b1;
        pick   = 2'(s);
      end
    end
    fo_start = !busy && pick_v;
    if (fo_start) begin
      next_st.pend[pick] = 1'b0;
      next_st.state      = UPFC_DETECT;
      next_st.target     = next_st.pend_mode[pick];
      next_st.busy_src   = pick;
      next_st.busy_src_v = 1'b1;
      next_st.init_f     = 1'b1;
      next_st.dcnt       = '0;
    end

    // failover sequence; hot reset has no input here
    unique case (st.state)
      UPFC_IDLE: begin
      end
      UPFC_DETECT: begin
        next_st.dcnt = st.dcnt + 5'h01;
        if (st.dcnt == 5'(UPFC_DETECT_CYC - 1)) begin
          next_st.cmode = st.target;
          next_st.state = UPFC_RETRAIN;
        end
      end
      UPFC_RETRAIN: begin
        if (fo_done) begin
          next_st.state      = UPFC_IDLE;
          next_st.done_f     = 1'b1;
          next_st.busy_src_v = 1'b0;
        end
      end
    endcase
    next_st.force_det = (next_st.state == UPFC_DETECT);
    next_st.retrain   = (next_st.state == UPFC_RETRAIN);
    next_st.mask      = next_st.force_det | next_st.retrain;

    // status flags cleared by writing one; a new set wins
    if (cfg_wr_i && cfg_idx_i == UPFC_IDX_STS && cfg_be_i[0]) begin
      if (cfg_wdata_i[UPFC_STS_INIT] && !fo_start) begin
        next_st.init_f = 1'b0;
      end
      if (cfg_wdata_i[UPFC_STS_DONE] && !fo_done) begin
        next_st.done_f = 1'b0;
      end
    end

    // domain reset masking
    next_st.int_rst = 1'b0;
    next_st.ext_rst = 1'b0;
    if (pa_dl_down_i && !st.ctl[UPFC_CTL_IDLD] &&
        !(in_fovr && st.ctl[UPFC_CTL_DFH])) begin
      next_st.int_rst = 1'b1;
      next_st.ext_rst = 1'b1;
    end
    if (pc_dl_down_i && !st.ctl[UPFC_CTL_EDLD] &&
        !(in_fovr && st.ctl[UPFC_CTL_DFH])) begin
      next_st.ext_rst = 1'b1;
    end
    if ((pa_ts1_hrst_i || hot_rst_i) && !st.ctl[UPFC_CTL_IDPROP]) begin
      next_st.int_rst = 1'b1;
    end
    if (pc_ts1_hrst_i && !st.ctl[UPFC_CTL_EDPROP]) begin
      next_st.ext_rst = 1'b1;
    end

    // gpio register
    if (cfg_wr_i && cfg_idx_i == UPFC_IDX_GPIO) begin
      if (cfg_be_i[0]) next_st.func = cfg_wdata_i[UPFC_GPIO_FUNC +: NPIN];
      if (cfg_be_i[1]) next_st.dir  = cfg_wdata_i[UPFC_GPIO_DIR  +: NPIN];
      if (cfg_be_i[2]) next_st.dout = cfg_wdata_i[UPFC_GPIO_DATA +: NPIN];
    end
    alt_out = '0;
    alt_out[0] = ~port_b_rst_i;
    alt_out[1] = ~port_c_rst_i;
    alt_out[4:2] = linkup_i;
    for (int p = 0; p < NPIN; p++) begin
      // pins 5 and up have no alternate output; failover pin is an input
      if (st.func[p]) begin
        next_st.goe[p]  = (p < 5);
        next_st.gout[p] = (p < 5) ? alt_out[p] : 1'b0;
      end else begin
        next_st.goe[p]  = st.dir[p];
        next_st.gout[p] = st.dout[p];
      end
    end

    // read mux
    next_st.rdata = '0;
    if (cfg_rd_i) begin
      unique case (cfg_idx_i)
        UPFC_IDX_CTL:   next_st.rdata = {24'h0, st.ctl};
        UPFC_IDX_STS:   next_st.rdata = {29'h0, st.done_f, st.init_f, st.cmode};
        UPFC_IDX_TIMER: next_st.rdata = 32'(wdt_count);
        UPFC_IDX_GPIO:  next_st.rdata = {8'h00, pins_sync, st.dir, st.func};
        default:        next_st.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st       <= '0;
      st.ctl   <= UPFC_CTL_RST;
      st.func  <= UPFC_GPIO_RST;
      st.dir   <= UPFC_GPIO_RST;
      st.state <= UPFC_IDLE;
    end else begin
      st <= next_st;
    end
  end

  assign cfg_rdata_o     = st.rdata;
  assign cfg_ack_o       = st.ack;
  assign gpio_out_o      = st.gout;
  assign gpio_oe_o       = st.goe;
  assign force_detect_o  = st.force_det;
  assign lane_swap_o     = st.cmode;
  assign retrain_o       = st.retrain;
  assign int_dom_rst_o   = st.int_rst;
  assign ext_dom_rst_o   = st.ext_rst;
  assign link_evt_mask_o = st.mask;
endmodule : upfc_top

// ---- upfc_wdt.sv ----
// microsecond watchdog countdown with one-to-zero expiry pulse
`timescale 1ns/1ps
module upfc_wdt
  import upfc_pkg::*;
#(
  parameter int CW   = 32,
  parameter int TICK = UPFC_TICK_CYC
) (
  input  wire logic          core_clk_i, // core clock
  input  wire logic          rstn_i,     // fundamental reset, active low
  input  wire logic          load_i,     // software write of count
  input  wire logic [CW-1:0] load_val_i, // value written
  output logic      [CW-1:0] count_o,    // current count
  output logic               expire_o    // pulse on one-to-zero step
);
  typedef struct packed {
    logic [CW-1:0] count;
    logic [7:0]    pre;
    logic          expire;
  } upfc_wdt_s;
  upfc_wdt_s st;
  upfc_wdt_s next_st;

  always_comb begin
    next_st        = st;
    next_st.expire = 1'b0;
    if (load_i) begin
      next_st.count = load_val_i;
      next_st.pre   = '0;
    end else if (st.count != '0) begin
      if (st.pre == 8'(TICK - 1)) begin
        next_st.pre   = '0;
        next_st.count = st.count - CW'(1);
        next_st.expire = (st.count == CW'(1));
      end else begin
        next_st.pre = st.pre + 8'h01;
      end
    end
  end

  // only fundamental reset clears the count; hot reset never reaches here
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign count_o  = st.count;
  assign expire_o = st.expire;
endmodule : upfc_wdt
